// ==== src/dsp_pkg.sv ====
// What this block does
// - Bits 7:6 select one of four modes.
// - Nine-bit modes: filter drops frames with ninth zero.
// - Mode 1: filter drops frames lacking valid stop.
// - Filter clear or mode 0: no effect.
// - Reception accepted only while receive enable set.
// - Nine-bit modes send tx_ninth_bit as ninth bit.
// - Bit 2 gets ninth, stop, or nothing.
// - Hardware writes only rx_ninth_bit and the flags.
// - Nine-bit modes: tx done after ninth bit.
// - Modes 0,1: tx done after eighth bit.
// - Nine-bit modes: rx done one clock after ninth.
// - Mode 1: rx done one clock after stop.
// - Mode 0: rx done after eight shift periods.
// - Hardware updates survive a concurrent firmware write.
// - Mode 0 shifts eight bits, clock sys/6.
// - Start, eight data, optional ninth, then stop.
// - Writing the data buffer starts transmission.
// - Reception starts by write (mode 0) or start bit.
`default_nettype none
package dsp_pkg;
  localparam logic [7:0] CTRL_ADDR    = 8'h98;
  localparam logic [7:0] DATA_ADDR    = 8'h99;
  localparam int         FIFO_WIDTH   = 8;
  localparam int         FIFO_DEPTH   = 4;
  localparam logic [3:0] M0_LAST      = 4'h5;
  localparam logic [3:0] M0_HALF      = 4'h3;
  localparam logic [3:0] M0_BIT_LAST  = 4'h7;
  localparam logic [3:0] OVS_LAST     = 4'hf;
  localparam logic [3:0] SAMPLE_PT    = 4'h7;
  localparam logic [3:0] M2_DIV_LAST  = 4'h1;
  localparam logic [3:0] TI_IDX8      = 4'h8;
  localparam logic [3:0] TI_IDX9      = 4'h9;
  localparam logic [3:0] STOP_IDX8    = 4'h9;
  localparam logic [3:0] STOP_IDX9    = 4'ha;
  localparam logic [3:0] RX_LAST_IDX  = 4'h9;

  typedef enum logic [1:0] {MODE_SHIFT, MODE_ASYNC8, MODE_ASYNC9_FIXED, MODE_ASYNC9_VAR} dsp_mode_t;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} dsp_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SHIFT0, RX_FIN} dsp_rx_state_t;

  typedef struct packed {
    dsp_mode_t mode;
    logic      multiproc_filter_en;
    logic      rx_enable;
    logic      tx_ninth_bit;
    logic      rx_ninth_bit;
    logic      tx_done_flag;
    logic      rx_done_flag;
  } dsp_ctrl_t;

  localparam dsp_ctrl_t CTRL_RESET = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } dsp_sfr_req_t;

  typedef struct packed {
    logic tx;
    logic rx_out;
    logic rx_oe;
  } dsp_pins_t;
endpackage
`default_nettype wire

// ==== src/dsp_serial_ctrl.sv ====
`default_nettype none
module dsp_fifo #(
  parameter int WIDTH = dsp_pkg::FIFO_WIDTH,
  parameter int DEPTH = dsp_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  import dsp_pkg::*;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } dsp_fifo_st_t;

  dsp_fifo_st_t s;
  dsp_fifo_st_t n;
  logic         push;
  logic         pop;

  assign in_ready  = (s.cnt != CW'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wp] = in_data;
      n.wp        = (s.wp == PW'(DEPTH - 1)) ? '0 : PW'(s.wp + 1'b1);
    end
    if (pop) begin
      n.rp = (s.rp == PW'(DEPTH - 1)) ? '0 : PW'(s.rp + 1'b1);
    end
    case ({push, pop})
      2'b10:   n.cnt = CW'(s.cnt + 1'b1);
      2'b01:   n.cnt = CW'(s.cnt - 1'b1);
      default: n.cnt = s.cnt;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

module dsp_serial_ctrl (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire dsp_pkg::dsp_sfr_req_t sfr_req,
  output logic                 [7:0] sfr_rdata,
  input  wire logic                  baud_tick,
  input  wire logic                  rx_in,
  output var dsp_pkg::dsp_pins_t     pins,
  output logic                       tx_buf_ready
);
  import dsp_pkg::*;

  typedef struct packed {
    dsp_ctrl_t     ctrl;
    logic [7:0]    rx_buf;
    logic [7:0]    rdata;
    dsp_tx_state_t tx_st;
    logic [3:0]    tx_div;
    logic [3:0]    tx_idx;
    logic [10:0]   tx_sh;
    dsp_rx_state_t rx_st;
    logic [3:0]    rx_div;
    logic [3:0]    rx_idx;
    logic [7:0]    rx_sh;
    logic          rx9;
    logic          rx_prev;
    logic [3:0]    m2div;
    dsp_pins_t     pins;
    logic          room;
  } dsp_state_t;

  dsp_state_t s;
  dsp_state_t n;
  logic       wr_ctrl;
  logic       wr_data;
  logic       nine;
  logic       tick;
  logic       tx_take;
  logic       accept;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;

  assign sfr_rdata    = s.rdata;
  assign pins         = s.pins;
  assign tx_buf_ready = s.room;

  assign wr_ctrl = sfr_req.wr && (sfr_req.addr == CTRL_ADDR);
  assign wr_data = sfr_req.wr && (sfr_req.addr == DATA_ADDR);
  assign nine    = s.ctrl.mode[1];
  // Mode 2 runs a fixed oversampling tick; modes 1 and 3 follow the timer tick.
  assign tick    = (s.ctrl.mode == MODE_ASYNC9_FIXED) ? (s.m2div == M2_DIV_LAST) : baud_tick;
  // Mode 0 shares the receive pin, so a shift transmit waits for a shift receive.
  assign tx_take = (s.tx_st == TX_IDLE) && fifo_out_valid && (s.rx_st != RX_SHIFT0);
  // The stop bit in mode 1 and the ninth bit in modes 2 and 3 both sit in rx9.
  assign accept  = (s.ctrl.mode == MODE_SHIFT) || !s.ctrl.multiproc_filter_en || s.rx9;

  dsp_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   (sfr_req.wdata),
    .in_valid  (wr_data),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (tx_take)
  );

  always_comb begin
    n         = s;
    n.room    = fifo_in_ready;
    n.rx_prev = rx_in;
    n.m2div   = (s.m2div == M2_DIV_LAST) ? '0 : 4'(s.m2div + 1'b1);
    n.rdata   = '0;
    if (sfr_req.rd && (sfr_req.addr == CTRL_ADDR)) begin
      n.rdata = s.ctrl;
    end else if (sfr_req.rd && (sfr_req.addr == DATA_ADDR)) begin
      n.rdata = s.rx_buf;
    end
    // Firmware write lands first so that hardware updates below override it.
    if (wr_ctrl) begin
      n.ctrl = dsp_ctrl_t'(sfr_req.wdata);
    end

    case (s.tx_st)
      TX_IDLE: begin
        if (tx_take) begin
          n.tx_st  = TX_SHIFT;
          n.tx_div = '0;
          n.tx_idx = '0;
          if (s.ctrl.mode == MODE_SHIFT) begin
            n.tx_sh = {3'b111, fifo_out_data};
          end else begin
            n.tx_sh = {1'b1, nine ? s.ctrl.tx_ninth_bit : 1'b1, fifo_out_data, 1'b0};
          end
        end
      end
      TX_SHIFT: begin
        if (s.ctrl.mode == MODE_SHIFT) begin
          n.tx_div = 4'(s.tx_div + 1'b1);
          if (s.tx_div == M0_LAST) begin
            n.tx_div = '0;
            n.tx_sh  = {1'b1, s.tx_sh[10:1]};
            n.tx_idx = 4'(s.tx_idx + 1'b1);
            if (s.tx_idx == M0_BIT_LAST) begin
              n.ctrl.tx_done_flag = 1'b1;
              n.tx_st             = TX_IDLE;
            end
          end
        end else if (tick) begin
          n.tx_div = 4'(s.tx_div + 1'b1);
          if (s.tx_div == OVS_LAST) begin
            n.tx_div = '0;
            n.tx_sh  = {1'b1, s.tx_sh[10:1]};
            n.tx_idx = 4'(s.tx_idx + 1'b1);
            if (s.tx_idx == (nine ? TI_IDX9 : TI_IDX8)) begin
              n.ctrl.tx_done_flag = 1'b1;
            end
            if (s.tx_idx == (nine ? STOP_IDX9 : STOP_IDX8)) begin
              n.tx_st = TX_IDLE;
            end
          end
        end
      end
      default: n.tx_st = TX_IDLE;
    endcase

    case (s.rx_st)
      RX_IDLE: begin
        n.rx_div = '0;
        n.rx_idx = '0;
        if (wr_ctrl && (n.ctrl.mode == MODE_SHIFT) && n.ctrl.rx_enable && !n.ctrl.rx_done_flag &&
            (s.tx_st == TX_IDLE) && !fifo_out_valid) begin
          n.rx_st = RX_SHIFT0;
        end else if ((s.ctrl.mode != MODE_SHIFT) && s.ctrl.rx_enable && s.rx_prev && !rx_in) begin
          n.rx_st = RX_ASYNC;
        end
      end
      RX_SHIFT0: begin
        n.rx_div = 4'(s.rx_div + 1'b1);
        if (s.rx_div == M0_LAST) begin
          n.rx_div = '0;
          n.rx_sh  = {rx_in, s.rx_sh[7:1]};
          n.rx_idx = 4'(s.rx_idx + 1'b1);
          if (s.rx_idx == M0_BIT_LAST) begin
            n.rx9   = s.ctrl.rx_ninth_bit;
            n.rx_st = RX_FIN;
          end
        end
      end
      RX_ASYNC: begin
        if (tick) begin
          n.rx_div = 4'(s.rx_div + 1'b1);
          if (s.rx_div == SAMPLE_PT) begin
            if (s.rx_idx == '0) begin
              // A start bit that is high again at mid-bit was a glitch.
              if (rx_in) begin
                n.rx_st = RX_IDLE;
              end
            end else if (s.rx_idx == RX_LAST_IDX) begin
              n.rx9   = rx_in;
              n.rx_st = RX_FIN;
            end else begin
              n.rx_sh = {rx_in, s.rx_sh[7:1]};
            end
          end
          if (s.rx_div == OVS_LAST) begin
            n.rx_div = '0;
            n.rx_idx = 4'(s.rx_idx + 1'b1);
          end
        end
      end
      RX_FIN: begin
        n.rx_st = RX_IDLE;
        if (accept) begin
          n.ctrl.rx_done_flag = 1'b1;
          n.rx_buf            = s.rx_sh;
          if (s.ctrl.mode != MODE_SHIFT) begin
            n.ctrl.rx_ninth_bit = s.rx9;
          end
        end
      end
      default: n.rx_st = RX_IDLE;
    endcase

    n.pins = '{tx: 1'b1, rx_out: 1'b1, rx_oe: 1'b0};
    if (n.ctrl.mode == MODE_SHIFT) begin
      if (n.tx_st == TX_SHIFT) begin
        n.pins.rx_oe  = 1'b1;
        n.pins.rx_out = n.tx_sh[0];
        n.pins.tx     = (n.tx_div >= M0_HALF);
      end else if (n.rx_st == RX_SHIFT0) begin
        n.pins.tx = (n.rx_div >= M0_HALF);
      end
    end else if (n.tx_st == TX_SHIFT) begin
      n.pins.tx = n.tx_sh[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s              <= '0;
      s.ctrl         <= CTRL_RESET;
      s.rx_prev      <= 1'b1;
      s.pins.tx      <= 1'b1;
      s.pins.rx_out  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_ti_sticky: assert property (s.ctrl.tx_done_flag && !wr_ctrl |=> s.ctrl.tx_done_flag)
    else $error("tx done flag dropped without a firmware write");
  chk_ri_sticky: assert property (s.ctrl.rx_done_flag && !wr_ctrl |=> s.ctrl.rx_done_flag)
    else $error("rx done flag dropped without a firmware write");
  chk_filter_block: assert property ((s.rx_st == RX_FIN) && (s.ctrl.mode != MODE_SHIFT) &&
      s.ctrl.multiproc_filter_en && !s.rx9 && !wr_ctrl |=> $stable(s.ctrl) && $stable(s.rx_buf))
    else $error("filtered frame changed control or buffer");
  chk_ri_timing: assert property ((s.rx_st == RX_ASYNC) && tick && (s.rx_div == SAMPLE_PT) &&
      (s.rx_idx == RX_LAST_IDX) && (!s.ctrl.multiproc_filter_en || rx_in) |=> ##1 s.ctrl.rx_done_flag)
    else $error("rx done flag not set one clock after last sample");
  chk_rb8_mode0: assert property ((s.rx_st == RX_FIN) && (s.ctrl.mode == MODE_SHIFT) && !wr_ctrl
      |=> $stable(s.ctrl.rx_ninth_bit))
    else $error("mode 0 reception altered the ninth bit field");
  chk_ren_gate: assert property ((s.rx_st == RX_IDLE) && !s.ctrl.rx_enable && !wr_ctrl
      |=> s.rx_st == RX_IDLE)
    else $error("reception started while disabled");
  chk_tx_ninth: assert property (tx_take && s.ctrl.mode[1] |=> s.tx_sh[9] == $past(s.ctrl.tx_ninth_bit))
    else $error("ninth transmit bit not taken from control");
  chk_ctrl_write: assert property (wr_ctrl |=> s.ctrl.mode == $past(sfr_req.wdata[7:6]))
    else $error("control write did not update mode");
  chk_m0_period: assert property (tx_take && (s.ctrl.mode == MODE_SHIFT) && !wr_ctrl
      |=> (s.tx_st == TX_SHIFT)[*8] ##41 (s.tx_st == TX_IDLE) && s.ctrl.tx_done_flag)
    else $error("mode 0 transmit did not take 48 clocks");

  cov_rx_done: cover property ((s.rx_st == RX_FIN) && accept);
  cov_rx_filtered: cover property ((s.rx_st == RX_FIN) && !accept);
  cov_tx_done9: cover property ($rose(s.ctrl.tx_done_flag) && nine);
  cov_fifo_full: cover property (!fifo_in_ready && wr_data);
endmodule
`default_nettype wire

// ==== testbench/dsp_term.sv ====
`default_nettype none
module dsp_term (
  input  wire logic sys_clk,
  input  wire logic line_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 32;
  logic [8:0] got;
  int         n_got;
  initial begin
    line_out = 1'b1;
    got      = 9'h000;
  end
  // Frame bits go out LSB first; the line rests high between frames.
  task automatic send(input logic [10:0] f, input int nb);
    for (int i = 0; i < nb; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge sys_clk);
    end
    line_out <= 1'b1;
  endtask
  // Samples nine bits at mid-bit after each start edge.
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge sys_clk);
      got[i] = line_in;
    end
    n_got++;
  end
endmodule
`default_nettype wire

// ==== testbench/test_debug_serial_port_control.sv ====
`default_nettype none
module test_debug_serial_port_control;
  import dsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic         sys_clk;
  logic         rst;
  dsp_sfr_req_t sfr_req;
  logic   [7:0] sfr_rdata;
  logic         baud_tick;
  wire logic    rx_in;
  dsp_pins_t    pins;
  logic         tx_buf_ready;
  logic         term_rx;
  int           n_fail;
  int           check_count;
  int           cyc;
  logic   [7:0] rb;
  logic   [7:0] exp_buf;
  logic   [7:0] m0_sh;
  assign rx_in = pins.rx_oe ? pins.rx_out : term_rx;
  dsp_serial_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .baud_tick(baud_tick), .rx_in(rx_in), .pins(pins), .tx_buf_ready(tx_buf_ready));
  dsp_term u_term (.sys_clk(sys_clk), .line_in(pins.tx), .line_out(term_rx));
  // Mode 0 transmit data is taken on each rising shift clock, as a shift register partner would.
  always @(posedge pins.tx) begin
    if (pins.rx_oe) m0_sh = {rx_in, m0_sh[7:1]};
  end
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // One tick every two clocks gives 32 clocks a bit, the same as the fixed rate.
  always @(posedge sys_clk) baud_tick <= #1 ~baud_tick;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge sys_clk);
    #1 sfr_req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1 sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge sys_clk);
    #1 sfr_req = '0;
    d = sfr_rdata;
  endtask
  task automatic wait_bit(input int b);
    for (int i = 0; i < 300; i++) begin
      rd(CTRL_ADDR, rb);
      if (rb[b] === 1'b1) break;
    end
  endtask
  task automatic t_regs();
    rd(CTRL_ADDR, rb);
    chk("ctrl reset", 8'h00, rb);
    wr(CTRL_ADDR, 8'hc8);
    rd(CTRL_ADDR, rb);
    chk("ctrl write", 8'hc8, rb);
    rd(8'h42, rb);
    chk("unmapped", 8'h00, rb);
  endtask
  task automatic t_tx(input logic [7:0] ctrl, input logic [7:0] d, input logic ninth);
    int n0;
    n0 = u_term.n_got;
    wr(CTRL_ADDR, ctrl);
    wr(DATA_ADDR, d);
    wait_bit(1);
    chk("tx done", 8'h02, rb & 8'h03);
    repeat (80) @(posedge sys_clk);
    chk("tx frames", 8'h01, 8'(u_term.n_got - n0));
    chk("tx byte", d, u_term.got[7:0]);
    chk("tx ninth", {7'h0, ninth}, {7'h0, u_term.got[8]});
    wr(CTRL_ADDR, ctrl);
    rd(CTRL_ADDR, rb);
    chk("tx cleared", ctrl, rb);
  endtask
  task automatic t_rx(input logic [7:0] ctrl, input logic [10:0] f, input int nb, input logic [2:0] lo,
                      input logic ld);
    wr(CTRL_ADDR, ctrl);
    u_term.send(f, nb);
    repeat (40) @(posedge sys_clk);
    rd(CTRL_ADDR, rb);
    chk("rx status", ctrl | {5'h0, lo}, rb);
    if (ld) exp_buf = f[8:1];
    rd(DATA_ADDR, rb);
    chk("rx buffer", exp_buf, rb);
  endtask
  task automatic t_fifo();
    int n0;
    n0 = u_term.n_got;
    wr(CTRL_ADDR, 8'h40);
    @(posedge sys_clk);
    for (int i = 1; i <= 6; i++) begin
      #1 sfr_req = '{addr: DATA_ADDR, wr: 1'b1, rd: 1'b0, wdata: 8'(i)};
      @(posedge sys_clk);
    end
    #1 sfr_req = '0;
    @(posedge sys_clk);
    #1 chk("fifo full", 8'h00, {7'h0, tx_buf_ready});
    repeat (1800) @(posedge sys_clk);
    chk("fifo frames", 8'h05, 8'(u_term.n_got - n0));
    chk("fifo last", 8'h05, u_term.got[7:0]);
    chk("fifo free", 8'h01, {7'h0, tx_buf_ready});
  endtask
  task automatic t_m0();
    wr(CTRL_ADDR, 8'h34);
    repeat (36) @(posedge sys_clk);
    rd(CTRL_ADDR, rb);
    chk("m0 early", 8'h34, rb);
    repeat (20) @(posedge sys_clk);
    rd(CTRL_ADDR, rb);
    chk("m0 done", 8'h35, rb);
    rd(DATA_ADDR, rb);
    chk("m0 data", 8'hff, rb);
    wr(CTRL_ADDR, 8'h00);
    wr(DATA_ADDR, 8'h6b);
    wait_bit(1);
    chk("m0 tx done", 8'h02, rb & 8'h03);
    chk("m0 tx data", 8'h6b, m0_sh);
  endtask
  initial begin
    rst = 1'b1;
    sfr_req = '0;
    baud_tick = 1'b0;
    exp_buf = 8'h00;
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_regs();
    t_tx(8'h88, 8'ha5, 1'b1);
    t_tx(8'hc0, 8'h3c, 1'b0);
    t_tx(8'h48, 8'h96, 1'b1);
    t_rx(8'hf0, {1'b1, 1'b0, 8'hee, 1'b0}, 11, 3'b000, 1'b0);
    t_rx(8'hf0, {1'b1, 1'b1, 8'h3c, 1'b0}, 11, 3'b101, 1'b1);
    t_rx(8'h70, {1'b0, 1'b0, 8'h81, 1'b0}, 10, 3'b000, 1'b0);
    t_rx(8'h70, {1'b0, 1'b1, 8'h81, 1'b0}, 10, 3'b101, 1'b1);
    t_rx(8'h90, {1'b1, 1'b0, 8'h5a, 1'b0}, 11, 3'b001, 1'b1);
    t_rx(8'h40, {1'b0, 1'b1, 8'h77, 1'b0}, 10, 3'b000, 1'b0);
    t_fifo();
    t_m0();
    give_verdict();
  end
endmodule
`default_nettype wire
